// ==== shared/vcp_cfg.svh ====
// Constants for the vector compare predicate unit
`ifndef VCP_CFG_SVH
`define VCP_CFG_SVH
`define VCP_VEC_W 128
`define VCP_FP_LANES 4
`define VCP_FP_W 32
`define VCP_EXP_HI 30
`define VCP_EXP_LO 23
`define VCP_MAN_HI 22
`define VCP_SIGN_BIT 31
`define VCP_EXP_ONES 8'hFF
`define VCP_EXP_ZERO 8'h00
`define VCP_MAN_ZERO 23'h000000
`define VCP_W8_LANES 16
`define VCP_W16_LANES 8
`endif

// ==== shared/vcp_pkg.sv ====
// Types for the vector compare predicate unit
package vcp_pkg;
   typedef enum logic [3:0] {
      VCP_OP_ALL_NAN,
      VCP_OP_ALL_NUMERIC,
      VCP_OP_ALL_NE,
      VCP_OP_ANY_EQ,
      VCP_OP_ALL_NGE,
      VCP_OP_ALL_NGT,
      VCP_OP_ALL_NLE,
      VCP_OP_ALL_NLT,
      VCP_OP_ALL_GT
   } vcp_op_t;

   typedef enum logic [1:0] {
      VCP_EL_B8,
      VCP_EL_H16,
      VCP_EL_W32,
      VCP_EL_FP32
   } vcp_elem_t;

   typedef struct packed {
      logic valid;
      vcp_op_t op;
      vcp_elem_t elem;
      logic is_signed;
      logic non_java_flush_bit;
      logic [127:0] a;
      logic [127:0] b;
   } vcp_req_t;

   typedef struct packed {
      logic valid;
      logic result;
   } vcp_rsp_t;
endpackage

// ==== hw/vcp_fp_lane.sv ====
// One single-precision lane: class, flush and ordered compare
`timescale 1ns/1ps
`include "vcp_cfg.svh"
module vcp_fp_lane (
   input wire logic [31:0] i_a,
   input wire logic [31:0] i_b,
   input wire logic i_flush,
   output logic o_a_nan,
   output logic o_unord,
   output logic o_eq,
   output logic o_gt,
   output logic o_lt
);
   wire logic [7:0] a_exp = i_a[`VCP_EXP_HI:`VCP_EXP_LO];
   wire logic [7:0] b_exp = i_b[`VCP_EXP_HI:`VCP_EXP_LO];
   wire logic a_man_nz = i_a[`VCP_MAN_HI:0] != `VCP_MAN_ZERO;
   wire logic b_man_nz = i_b[`VCP_MAN_HI:0] != `VCP_MAN_ZERO;
   wire logic b_nan = (b_exp == `VCP_EXP_ONES) && b_man_nz;
   // Denormal flush keeps the sign; signed zeros compare equal anyway
   wire logic a_den = (a_exp == `VCP_EXP_ZERO) && a_man_nz;
   wire logic b_den = (b_exp == `VCP_EXP_ZERO) && b_man_nz;
   wire logic [31:0] a_f = (i_flush && a_den) ? {i_a[31], 31'h0} : i_a; // see [RL4]
   wire logic [31:0] b_f = (i_flush && b_den) ? {i_b[31], 31'h0} : i_b; // see [RL4]
   wire logic a_zero = a_f[30:0] == 31'h0;
   wire logic b_zero = b_f[30:0] == 31'h0;
   wire logic both_zero = a_zero && b_zero;
   wire logic a_neg = a_f[`VCP_SIGN_BIT];
   wire logic b_neg = b_f[`VCP_SIGN_BIT];
   wire logic mag_gt = a_f[30:0] > b_f[30:0];
   wire logic mag_lt = a_f[30:0] < b_f[30:0];
   wire logic raw_gt = (a_neg != b_neg) ? b_neg : (a_neg ? mag_lt : mag_gt);
   wire logic raw_lt = (a_neg != b_neg) ? a_neg : (a_neg ? mag_gt : mag_lt);
   // NaN test reads the raw operand, never the flushed one
   assign o_a_nan = (a_exp == `VCP_EXP_ONES) && a_man_nz; // see [RL2]
   assign o_unord = o_a_nan || b_nan;
   assign o_eq = !o_unord && (both_zero || (a_f == b_f));
   assign o_gt = !o_unord && !both_zero && raw_gt;
   assign o_lt = !o_unord && !both_zero && raw_lt;
endmodule

// ==== hw/vcp_top.sv ====
// Vector compare predicate unit, one registered result per request
// Contract
// [RL1] All-NaN returns 1 only when all four float lanes of a are NaN.
// [RL2] All-NaN and all-numeric ignore the flush mode bit.
// [RL3] All-not-equal returns 1 when no lane pair is equal.
// [RL4] With the flush bit set, denormal float lanes become zero first.
// [RL5] All-not-ge returns 1 when each pair is less-than or unordered.
// [RL6] All-not-gt returns 1 when each pair is less-or-equal or unordered.
// [RL7] All-not-le returns 1 when each pair is greater-than or unordered.
// [RL8] All-not-lt returns 1 when each pair is greater-or-equal or unordered.
// [RL9] All-numeric returns 1 only when no float lane of a is NaN.
// [RL10] Any-equal returns 1 when at least one lane pair is equal.
// [RL11] Equality tests split operands into 16x8, 8x16 or 4x32 lanes.
// [RL12] Unordered float predicates exist only for four float lanes.
// [RL13] All-greater returns 1 only when every a lane exceeds its b lane.
// [RL14] Integer lane equality is bitwise and ignores signedness.
// [RL15] All-tests AND the lane results, any-tests OR them.
`timescale 1ns/1ps
`include "vcp_cfg.svh"
module vcp_top #(
   parameter int VEC_W = `VCP_VEC_W
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire vcp_pkg::vcp_req_t i_req,
   output vcp_pkg::vcp_rsp_t o_rsp,
   output logic o_illegal
);
   ////////////////////////////////////////////////////////////////////
   // Integer lanes
   logic [15:0] eq8;
   logic [7:0] eq16;
   logic [3:0] eq32;
   logic [15:0] gtu8;
   logic [15:0] gts8;
   logic [7:0] gtu16;
   logic [7:0] gts16;
   logic [3:0] gtu32;
   logic [3:0] gts32;
   genvar g;
   generate
      for (g = 0; g < `VCP_W8_LANES; g++) begin : g_b
         wire logic [7:0] a8 = i_req.a[g*8 +: 8];
         wire logic [7:0] b8 = i_req.b[g*8 +: 8];
         assign eq8[g] = a8 == b8; // see [RL14]
         assign gtu8[g] = a8 > b8;
         assign gts8[g] = $signed(a8) > $signed(b8);
      end
      for (g = 0; g < `VCP_W16_LANES; g++) begin : g_h
         wire logic [15:0] a16 = i_req.a[g*16 +: 16];
         wire logic [15:0] b16 = i_req.b[g*16 +: 16];
         assign eq16[g] = a16 == b16; // see [RL14]
         assign gtu16[g] = a16 > b16;
         assign gts16[g] = $signed(a16) > $signed(b16);
      end
      for (g = 0; g < `VCP_FP_LANES; g++) begin : g_w
         wire logic [31:0] a32 = i_req.a[g*32 +: 32];
         wire logic [31:0] b32 = i_req.b[g*32 +: 32];
         assign eq32[g] = a32 == b32; // see [RL14]
         assign gtu32[g] = a32 > b32;
         assign gts32[g] = $signed(a32) > $signed(b32);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Float lanes
   logic [3:0] f_nan;
   logic [3:0] f_un;
   logic [3:0] f_eq;
   logic [3:0] f_gt;
   logic [3:0] f_lt;
   generate
      for (g = 0; g < `VCP_FP_LANES; g++) begin : g_f
         vcp_fp_lane u_lane (
            .i_a(i_req.a[g*32 +: 32]),
            .i_b(i_req.b[g*32 +: 32]),
            .i_flush(i_req.non_java_flush_bit),
            .o_a_nan(f_nan[g]),
            .o_unord(f_un[g]),
            .o_eq(f_eq[g]),
            .o_gt(f_gt[g]),
            .o_lt(f_lt[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Selection and reduction
   wire logic is_fp = i_req.elem == vcp_pkg::VCP_EL_FP32;
   // Lanes widened to 16 bits so one reduction serves every width
   logic [15:0] eq_l;
   logic [15:0] gt_l;
   logic [15:0] lane_mask;
   always_comb begin
      eq_l = 16'h0000;
      gt_l = 16'h0000;
      lane_mask = 16'hFFFF;
      case (i_req.elem)
         vcp_pkg::VCP_EL_B8: begin // see [RL11]
            eq_l = eq8;
            gt_l = i_req.is_signed ? gts8 : gtu8;
         end
         vcp_pkg::VCP_EL_H16: begin // see [RL11]
            eq_l = {8'h00, eq16};
            gt_l = {8'h00, i_req.is_signed ? gts16 : gtu16};
            lane_mask = 16'h00FF;
         end
         vcp_pkg::VCP_EL_W32: begin // see [RL11]
            eq_l = {12'h000, eq32};
            gt_l = {12'h000, i_req.is_signed ? gts32 : gtu32};
            lane_mask = 16'h000F;
         end
         default: begin
            eq_l = {12'h000, f_eq};
            gt_l = {12'h000, f_gt};
            lane_mask = 16'h000F;
         end
      endcase
   end

   wire logic any_eq = |(eq_l & lane_mask); // see [RL10] [RL15]
   wire logic none_eq = ~any_eq; // see [RL3] [RL15]
   wire logic all_gt = &(gt_l | ~lane_mask); // see [RL13] [RL15]
   wire logic all_nan = &f_nan; // see [RL1] [RL15]
   wire logic all_num = ~|f_nan; // see [RL9] [RL15]
   wire logic all_nge = &(f_lt | f_un); // see [RL5] [RL15]
   wire logic all_ngt = &(f_lt | f_eq | f_un); // see [RL6] [RL15]
   wire logic all_nle = &(f_gt | f_un); // see [RL7] [RL15]
   wire logic all_nlt = &(f_gt | f_eq | f_un); // see [RL8] [RL15]

   wire logic fp_only = (i_req.op == vcp_pkg::VCP_OP_ALL_NAN)
      || (i_req.op == vcp_pkg::VCP_OP_ALL_NUMERIC)
      || (i_req.op == vcp_pkg::VCP_OP_ALL_NGE)
      || (i_req.op == vcp_pkg::VCP_OP_ALL_NGT)
      || (i_req.op == vcp_pkg::VCP_OP_ALL_NLE)
      || (i_req.op == vcp_pkg::VCP_OP_ALL_NLT);
   // Float-only tests on integer lanes are refused and return 0
   wire logic illegal_d = fp_only && !is_fp; // see [RL12]

   logic res_d;
   always_comb begin
      res_d = 1'b0;
      case (i_req.op)
         vcp_pkg::VCP_OP_ALL_NAN: res_d = all_nan;
         vcp_pkg::VCP_OP_ALL_NUMERIC: res_d = all_num;
         vcp_pkg::VCP_OP_ALL_NE: res_d = none_eq;
         vcp_pkg::VCP_OP_ANY_EQ: res_d = any_eq;
         vcp_pkg::VCP_OP_ALL_NGE: res_d = all_nge;
         vcp_pkg::VCP_OP_ALL_NGT: res_d = all_ngt;
         vcp_pkg::VCP_OP_ALL_NLE: res_d = all_nle;
         vcp_pkg::VCP_OP_ALL_NLT: res_d = all_nlt;
         vcp_pkg::VCP_OP_ALL_GT: res_d = all_gt;
         default: res_d = 1'b0;
      endcase
      if (illegal_d) begin
         res_d = 1'b0; // see [RL12]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rsp <= '0;
         o_illegal <= 1'b0;
      end else begin
         o_rsp.valid <= i_req.valid;
         o_rsp.result <= i_req.valid & res_d;
         o_illegal <= i_req.valid & illegal_d;
      end
   end
endmodule

// ==== testbench/vcp_properties.sv ====
// Port-level properties of the vector compare predicate unit
`timescale 1ns/1ps
module vcp_checker (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire vcp_pkg::vcp_req_t i_req,
   input wire vcp_pkg::vcp_rsp_t o_rsp,
   input wire logic o_illegal
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic v = i_req.valid;
   wire logic fp = i_req.elem == vcp_pkg::VCP_EL_FP32;
   // Identical operands give a known lane outcome without a reference model
   wire logic eqv = v && i_req.a == i_req.b;
   wire logic nan0 = (&i_req.a[30:23]) && (|i_req.a[22:0]);
   wire logic k_ne = i_req.op == vcp_pkg::VCP_OP_ALL_NE;
   wire logic k_eq = i_req.op == vcp_pkg::VCP_OP_ANY_EQ;
   wire logic k_gt = i_req.op == vcp_pkg::VCP_OP_ALL_GT;
   wire logic k_nan = i_req.op == vcp_pkg::VCP_OP_ALL_NAN;
   wire logic k_num = i_req.op == vcp_pkg::VCP_OP_ALL_NUMERIC;
   wire logic k_nge = i_req.op == vcp_pkg::VCP_OP_ALL_NGE;
   wire logic fo = v && !(k_ne || k_eq || k_gt);
   ////////////////////////////////////////////////////////////////////////
   property p_ill; fo && !fp |=> o_illegal && !o_rsp.result; endproperty
   a_ill: assert property (p_ill) else $error("illegal missed");
   property p_leg; v && (fp || !fo) |=> !o_illegal; endproperty
   a_leg: assert property (p_leg) else $error("legal flagged");
   property p_ne; eqv && !fp && k_ne |=> !o_rsp.result; endproperty
   a_ne: assert property (p_ne) else $error("all_ne on equal");
   property p_eq; eqv && !fp && k_eq |=> o_rsp.result; endproperty
   a_eq: assert property (p_eq) else $error("any_eq missed");
   property p_nan; v && fp && !nan0 && k_nan |=> !o_rsp.result; endproperty
   a_nan: assert property (p_nan) else $error("all_nan wrong");
   property p_num; v && fp && nan0 && k_num |=> !o_rsp.result; endproperty
   a_num: assert property (p_num) else $error("all_num wrong");
   property p_gt; eqv && k_gt |=> !o_rsp.result; endproperty
   a_gt: assert property (p_gt) else $error("all_gt on equal");
   property p_nge; eqv && fp && !nan0 && k_nge |=> !o_rsp.result; endproperty
   a_nge: assert property (p_nge) else $error("all_nge wrong");
   property p_idle; !v |=> !o_rsp.valid && !o_rsp.result; endproperty
   a_idle: assert property (p_idle) else $error("result without request");
   c_ill: cover property (fo && !fp);
   c_nan: cover property (v && fp && k_nan ##1 o_rsp.result);
   c_eq: cover property (eqv && k_eq);
endmodule
bind vcp_top vcp_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_req(i_req), .o_rsp(o_rsp), .o_illegal(o_illegal));

// ==== testbench/tb_vector_compare_predicates.sv ====
// Self-checking bench for the vector compare predicate unit
`timescale 1ns/1ps
module tb_vector_compare_predicates;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   vcp_pkg::vcp_req_t i_req = '0;
   vcp_pkg::vcp_rsp_t o_rsp;
   logic o_illegal;
   wire logic res = o_rsp.result;
   logic [3:0] exp_q[$];
   logic [3:0] e;
   int bad_count = 0;
   int samples_checked = 0;
   always #2.5 i_clk = ~i_clk;
   vcp_top u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
      .o_rsp(o_rsp), .o_illegal(o_illegal));
   ////////////////////////////////////////////////////////////////////////
   // Ordering key; both zeros collapse so that +0 equals -0
   function automatic logic [31:0] fkey(logic [31:0] x, logic f);
      if (f && x[30:23] == 8'h00) x[30:0] = 31'h0;
      if (x[30:0] == 31'h0) x = 32'h0;
      return x[31] ? ~x : {1'b1, x[30:0]};
   endfunction
   function automatic logic [3:0] model(vcp_pkg::vcp_req_t r);
      int w;
      logic [31:0] x, y, m;
      logic ef, n, u, q, g, l;
      logic [8:0] acc;
      logic [1:0] c;
      ef = r.elem == vcp_pkg::VCP_EL_FP32;
      w = r.elem == vcp_pkg::VCP_EL_B8 ? 8 :
         r.elem == vcp_pkg::VCP_EL_H16 ? 16 : 32;
      m = 32'hFFFFFFFF >> (32 - w);
      acc = 9'h1F7;
      for (int i = 0; i < 128 / w; i++) begin
         x = 32'(r.a >> (i * w)) & m;
         y = 32'(r.b >> (i * w)) & m;
         n = ef && (&x[30:23]) && (|x[22:0]);
         u = n || (ef && (&y[30:23]) && (|y[22:0]));
         if (ef) begin
            x = fkey(x, r.non_java_flush_bit);
            y = fkey(y, r.non_java_flush_bit);
         end else if (r.is_signed) begin
            x = x ^ (m ^ (m >> 1));
            y = y ^ (m ^ (m >> 1));
         end
         q = !u && x == y;
         g = !u && x > y;
         l = !u && x < y;
         acc = acc & {g, !l, !(l | q), !g, l | u, 1'b1, !q, !n, n};
         acc[3] = acc[3] | q;
      end
      c = r.op inside {vcp_pkg::VCP_OP_ALL_NE, vcp_pkg::VCP_OP_ANY_EQ} ? 2'h0
         : r.op == vcp_pkg::VCP_OP_ALL_GT ? 2'h1 : r.op inside
         {vcp_pkg::VCP_OP_ALL_NAN, vcp_pkg::VCP_OP_ALL_NUMERIC} ? 2'h2 : 2'h3;
      if (c == 2'h2 || c == 2'h3) begin
         if (!ef) return {c, 2'b10};
      end
      return {c, 1'b0, acc[r.op]};
   endfunction
   task automatic chk(string name, logic ex, logic got);
      samples_checked++;
      if (got !== ex) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", name, ex, got);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) if (o_rsp.valid === 1'b1) begin
      e = exp_q.pop_front();
      case (e[3:2])
         2'h0: chk("eq", e[0], res);
         2'h1: chk("gt", e[0], res);
         2'h2: chk("class", e[0], res);
         default: chk("order", e[0], res);
      endcase
      chk("illegal", e[1], o_illegal);
   end
   initial begin
      #60us;
      bad_count++;
      give_verdict();
   end
   initial begin
      vcp_pkg::vcp_req_t r;
      void'($urandom(22235));
      repeat (5) @(posedge i_clk);
      i_reset_n <= 1'b1;
      // Test 0 integer lanes, 1 float lanes, 2 everything mixed
      for (int t = 0; t < 3; t++) begin
         repeat (1500) begin
            @(posedge i_clk);
            r.valid = $urandom % 4 != 0;
            r.op = vcp_pkg::vcp_op_t'($urandom % 9);
            r.elem = vcp_pkg::vcp_elem_t'(t == 1 ? 3 : $urandom % (t ? 4 : 3));
            r.is_signed = 1'($urandom);
            r.non_java_flush_bit = 1'($urandom);
            r.a = {$urandom, $urandom, $urandom, $urandom};
            r.b = {$urandom, $urandom, $urandom, $urandom};
            // Force NaN, infinity, zero and denormal exponents often
            for (int k = 0; k < 4; k++) begin
               if ($urandom % 2) r.a[k*32+23+:8] = {8{$urandom % 2 == 1}};
               if ($urandom % 2) r.b[k*32+23+:8] = {8{$urandom % 2 == 1}};
            end
            // Now and then every a lane is NaN, else all-NaN seldom returns 1
            if ($urandom % 8 == 0) r.a = r.a | {4{32'h7F800001}};
            case ($urandom % 3)
               1: r.b = r.a;
               2: r.b = r.a & {4{32'hFF800000}};
               default: ;
            endcase
            i_req <= r;
            if (r.valid) exp_q.push_back(model(r));
         end
         $display("test %0d done", t);
      end
      @(posedge i_clk) i_req.valid <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk("drained", 1'b1, exp_q.size() == 0);
      give_verdict();
   end
endmodule
